// ===== rtl/sap_pkg.sv
// Purpose: Shared constants and types of the serial auto poll sequencer.
// Assumes: 250 MHz core clock; holding registers are 16 bits wide.
// Notes: The table layout constants describe one 13-word command entry.
package sap_pkg;
   // Holding register map of the polling table.
   localparam logic [15:0] SAP_TABLE_BASE = 16'h1838;
   localparam int SAP_ENTRY_WORDS = 13;
   localparam int SAP_MAX_ENTRIES = 10;
   localparam int SAP_TABLE_WORDS = SAP_ENTRY_WORDS * SAP_MAX_ENTRIES;
   // Word positions inside one entry.
   localparam int SAP_W_LEN = 0;
   localparam int SAP_W_TMO = 1;
   localparam int SAP_W_IVL = 2;
   localparam int SAP_W_CMD = 3;
   // Legal command length range in bytes.
   localparam logic [15:0] SAP_LEN_MIN = 16'h0001;
   localparam logic [15:0] SAP_LEN_MAX = 16'h0014;
   // Bus address answered while in configuration mode.
   localparam logic [7:0] SAP_CFG_ADDR = 8'h01;
   // Modbus CRC-16 constants (reflected polynomial).
   localparam logic [15:0] SAP_CRC_INIT = 16'hFFFF;
   localparam logic [15:0] SAP_CRC_POLY = 16'hA001;
   // Timing: clock period and one millisecond, both in picoseconds.
   localparam int SAP_CLK_PERIOD_PS = 4000;
   localparam int SAP_MS_PS = 1000000000;
   localparam int SAP_MS_CYCLES = SAP_MS_PS / SAP_CLK_PERIOD_PS;

   // Sequencer states.
   typedef enum logic [2:0] {
      SAP_IDLE,
      SAP_SEND,
      SAP_CRC_LO,
      SAP_CRC_HI,
      SAP_DRAIN,
      SAP_TMO,
      SAP_IVL
   } sap_state_e;
endpackage

// ===== rtl/sap_sequencer.sv
// Purpose: Stored-command serial polling sequencer with holding-register table.
// Assumes: All inputs are synchronous to clock_i; reset is synchronous and active high.
// Notes: Bytes leave through a two-entry buffer; the selected port is shown beside each byte.

module sap_sequencer
   import sap_pkg::*;
#(
   parameter int MAX_ENTRIES = SAP_MAX_ENTRIES,
   parameter int MS_CYCLES = SAP_MS_CYCLES
) (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rst_i,
   // Operating mode and options.
   input wire logic slave_mode_i,
   input wire logic config_mode_i,
   input wire logic [7:0] own_addr_i,
   input wire logic crc_off_i,
   input wire logic ttl_sel_i,
   // Holding register access from the decoded bus requests.
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   output logic [15:0] reg_rdata_o,
   output logic reg_hit_o,
   output logic [7:0] ans_addr_o,
   // Serial byte stream towards the selected port.
   output logic [7:0] tx_data_o,
   output logic tx_valid_o,
   output logic tx_ttl_o,
   input wire logic tx_ready_i,
   // Sequencer status.
   output logic busy_o,
   output logic [3:0] entry_o
);

   localparam int PW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

   // Refuse settings the table decode and timer cannot serve.
   if (MAX_ENTRIES < 1 || MAX_ENTRIES > SAP_MAX_ENTRIES) begin : g_chk_ent
      $error("MAX_ENTRIES must lie between 1 and 10");
   end
   if (MS_CYCLES < 1) begin : g_chk_ms
      $error("MS_CYCLES must be at least 1");
   end

   // Complete state of the block.
   typedef struct packed {
      logic [SAP_TABLE_WORDS-1:0][15:0] tbl;
      sap_state_e state;
      logic [3:0] entry;
      logic [4:0] bidx;
      logic [15:0] crc;
      logic [15:0] ms_left;
      logic [PW-1:0] pre;
      logic v0;
      logic v1;
      logic [7:0] d0;
      logic [7:0] d1;
      logic ttl;
      logic [15:0] rdata;
      logic hit;
      logic [7:0] ans;
      logic busy;
   } sap_st_s;

   sap_st_s q_r;
   sap_st_s q_nxt;

   // Decodes a holding register address into hit flag and flat table index.
   function automatic logic [8:0] sap_decode(input logic [15:0] addr);
      logic [15:0] off;
      off = addr - SAP_TABLE_BASE;
      if (addr >= SAP_TABLE_BASE && off < 16'(SAP_TABLE_WORDS)) begin
         return {1'b1, off[7:0]};
      end
      return 9'h000;
   endfunction

   // Folds one byte into a running Modbus CRC.
   function automatic logic [15:0] sap_crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ SAP_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // Next-state logic for table access, sequencing, timing and buffering.
   always_comb begin
      logic [8:0] dec_w;
      logic [8:0] dec_r;
      logic [7:0] ebase;
      logic [15:0] len;
      logic [15:0] word;
      logic [7:0] pbyte;
      logic push;
      logic room;
      logic tick;
      logic [3:0] nxt_ent;
      q_nxt = q_r;
      dec_w = sap_decode(reg_addr_i);
      dec_r = sap_decode(reg_addr_i);
      ebase = 8'(q_r.entry) * 8'(SAP_ENTRY_WORDS);
      len = q_r.tbl[ebase + 8'(SAP_W_LEN)];
      word = q_r.tbl[ebase + 8'(SAP_W_CMD) + 8'(q_r.bidx[4:1])];
      pbyte = 8'h00;
      push = 1'b0;
      room = !q_r.v1;
      tick = (q_r.pre == PW'(MS_CYCLES - 1));
      nxt_ent = (q_r.entry == 4'(MAX_ENTRIES - 1)) ? 4'h0 : q_r.entry + 4'h1;

      if (reg_wr_i && dec_w[8]) begin
         q_nxt.tbl[dec_w[7:0]] = reg_wdata_i;
      end
      // Reads answer one cycle later; unmapped reads return zero and no hit.
      q_nxt.hit = reg_rd_i && dec_r[8];
      q_nxt.rdata = (reg_rd_i && dec_r[8]) ? q_r.tbl[dec_r[7:0]] : 16'h0000;

      q_nxt.ans = config_mode_i ? SAP_CFG_ADDR : own_addr_i;

      // Millisecond prescaler.
      q_nxt.pre = tick ? '0 : q_r.pre + PW'(1);

      // Buffer drain side: head leaves when the receiver takes it.
      if (q_r.v0 && tx_ready_i) begin
         q_nxt.v0 = q_r.v1;
         q_nxt.d0 = q_r.d1;
         q_nxt.v1 = 1'b0;
      end

      unique case (q_r.state)
         SAP_IDLE: begin
            if (len >= SAP_LEN_MIN && len <= SAP_LEN_MAX) begin
               if (!q_r.v0 && !q_r.v1) begin
                  q_nxt.ttl = ttl_sel_i;
                  q_nxt.bidx = 5'h00;
                  q_nxt.crc = SAP_CRC_INIT;
                  q_nxt.state = SAP_SEND;
               end
            end else begin
               q_nxt.entry = nxt_ent;
            end
         end
         SAP_SEND: begin
            if (room) begin
               pbyte = q_r.bidx[0] ? word[7:0] : word[15:8];
               push = 1'b1;
               q_nxt.crc = sap_crc_byte(q_r.crc, pbyte);
               q_nxt.bidx = q_r.bidx + 5'h01;
               if (16'(q_r.bidx) == len - 16'h0001) begin
                  q_nxt.state = crc_off_i ? SAP_DRAIN : SAP_CRC_LO;
               end
            end
         end
         SAP_CRC_LO: begin
            if (room) begin
               pbyte = q_r.crc[7:0];
               push = 1'b1;
               q_nxt.state = SAP_CRC_HI;
            end
         end
         SAP_CRC_HI: begin
            if (room) begin
               pbyte = q_r.crc[15:8];
               push = 1'b1;
               q_nxt.state = SAP_DRAIN;
            end
         end
         SAP_DRAIN: begin
            if (!q_nxt.v0 && !q_nxt.v1) begin
               q_nxt.ms_left = q_r.tbl[ebase + 8'(SAP_W_TMO)];
               q_nxt.pre = '0;
               q_nxt.state = SAP_TMO;
            end
         end
         SAP_TMO: begin
            if (q_r.ms_left == 16'h0000) begin
               q_nxt.ms_left = {8'h00, q_r.tbl[ebase + 8'(SAP_W_IVL)][7:0]};
               q_nxt.pre = '0;
               q_nxt.state = SAP_IVL;
            end else if (tick) begin
               q_nxt.ms_left = q_r.ms_left - 16'h0001;
            end
         end
         SAP_IVL: begin
            if (q_r.ms_left == 16'h0000) begin
               q_nxt.entry = nxt_ent;
               q_nxt.state = SAP_IDLE;
            end else if (tick) begin
               q_nxt.ms_left = q_r.ms_left - 16'h0001;
            end
         end
      endcase

      // Buffer fill side: byte goes to the first free slot.
      if (push) begin
         if (!q_nxt.v0) begin
            q_nxt.v0 = 1'b1;
            q_nxt.d0 = pbyte;
         end else begin
            q_nxt.v1 = 1'b1;
            q_nxt.d1 = pbyte;
         end
      end

      if (!slave_mode_i) begin
         q_nxt.state = SAP_IDLE;
         q_nxt.entry = 4'h0;
      end

      // Busy flag is registered so the status output comes from a flip-flop.
      q_nxt.busy = (q_nxt.state != SAP_IDLE);
   end

   // State register.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   // Outputs come straight from the state register.
   assign reg_rdata_o = q_r.rdata;
   assign reg_hit_o = q_r.hit;
   assign ans_addr_o = q_r.ans;
   assign tx_data_o = q_r.d0;
   assign tx_valid_o = q_r.v0;
   assign tx_ttl_o = q_r.ttl;
   assign busy_o = q_r.busy;
   assign entry_o = q_r.entry;

endmodule // sap_sequencer

// ===== sim/sap_sequencer_sva.sv
// Purpose: Port checks of the polling sequencer.
// Assumes: One clock, synchronous active high reset.
// Notes: Bound to every sequencer instance.
module sap_sequencer_sva
   import sap_pkg::*;
#(parameter int MAX_ENTRIES = SAP_MAX_ENTRIES) (
   // Watched inputs.
   input wire logic clock_i, rst_i, slave_mode_i, config_mode_i, reg_rd_i, tx_ready_i,
   input wire logic [7:0] own_addr_i,
   input wire logic [15:0] reg_addr_i,
   // Watched outputs.
   input wire logic [15:0] reg_rdata_o,
   input wire logic reg_hit_o, tx_valid_o, tx_ttl_o, busy_o,
   input wire logic [7:0] ans_addr_o, tx_data_o,
   input wire logic [3:0] entry_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   ans_cfg_a: assert property (config_mode_i |=> ans_addr_o == SAP_CFG_ADDR)
      else $error("answer address not fixed");
   ans_own_a: assert property (!rst_i && !config_mode_i |=> ans_addr_o == $past(own_addr_i))
      else $error("answer address not own");
   byte_hold_a: assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable({tx_data_o, tx_ttl_o})) else $error("byte lost before take");
   slave_only_a: assert property (!slave_mode_i |=> !busy_o)
      else $error("busy outside slave role");
   entry_max_a: assert property (entry_o < MAX_ENTRIES)
      else $error("entry index out of range");
   read_hit_a: assert property (reg_rd_i && reg_addr_i == SAP_TABLE_BASE |=> reg_hit_o)
      else $error("table base not mapped");
   unmapped_a: assert property (reg_rd_i && reg_addr_i < SAP_TABLE_BASE |=>
      !reg_hit_o && reg_rdata_o == 16'h0000) else $error("unmapped read answered");
   read_idle_a: assert property (!reg_rd_i |=> !reg_hit_o)
      else $error("hit without read");
   take_c: cover property (tx_valid_o && tx_ready_i);
   stall_c: cover property ((tx_valid_o && !tx_ready_i) [*2]);
   wrap_c: cover property (entry_o == 4'h1 ##[1:300] entry_o == 4'h0 && busy_o);
endmodule // sap_sequencer_sva
bind sap_sequencer sap_sequencer_sva #(.MAX_ENTRIES(MAX_ENTRIES)) sva_u (.clock_i, .rst_i,
   .slave_mode_i, .config_mode_i, .reg_rd_i, .tx_ready_i, .own_addr_i, .reg_addr_i,
   .reg_rdata_o, .reg_hit_o, .tx_valid_o, .tx_ttl_o, .busy_o, .ans_addr_o, .tx_data_o,
   .entry_o);

// ===== sim/sap_sink.sv
// Purpose: Serial instrument that takes the polled bytes.
// Assumes: Ready changes only just after a rising edge.
// Notes: slow_i halves the take rate; stall_i refuses every byte.
module sap_sink (
   // Clock and pacing.
   input wire logic clock_i,
   input wire logic slow_i,
   input wire logic stall_i,
   // Byte stream.
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   input wire logic tx_ttl_i,
   output logic tx_ready_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int cyc = 0;
   logic [8:0] rx_q[$];
   int ts_q[$];
   // Records each taken byte with its port and cycle.
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (tx_valid_i && tx_ready_o) begin
         rx_q.push_back({tx_ttl_i, tx_data_i});
         ts_q.push_back(cyc);
      end
      tx_ready_o <= !stall_i && !(slow_i && tx_ready_o);
   end
endmodule // sap_sink

// ===== sim/sap_sequencer_tb.sv
// Purpose: Self-checking bench of the polling sequencer.
// Assumes: One millisecond shortened to four cycles.
// Notes: Table rows first, then streams, stalls and mode checks.
module sap_sequencer_tb import sap_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MS = 4;
   logic clock_i = 1'b0, rst_i = 1'b1, slave_mode_i = 1'b0, config_mode_i = 1'b0;
   logic crc_off_i = 1'b0, ttl_sel_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, tx_ready_i;
   logic slow = 1'b1, stall = 1'b0, reg_hit_o, tx_valid_o, tx_ttl_o, busy_o;
   logic [7:0] own_addr_i = 8'h42, tx_data_o, ans_addr_o;
   logic [15:0] reg_addr_i = 16'h0000, reg_wdata_i = 16'h0000, reg_rdata_o;
   logic [3:0] entry_o;
   logic [8:0] exp[$];
   int error_cnt = 0, compares = 0;
   // each entry is length, timeout and interval words, then the bytes.
   // the third column is the value expected on read-back, zero where the address is unmapped.
   logic [15:0] rows[10][3] = '{'{16'h1838, 16'h0003, 16'h0003}, '{16'h1839, 16'h0002, 16'h0002},
      '{16'h183A, 16'h0003, 16'h0003}, '{16'h183B, 16'h0503, 16'h0503},
      '{16'h183C, 16'h00AA, 16'h00AA}, '{16'h1845, 16'h0001, 16'h0001},
      '{16'h1848, 16'h7E00, 16'h7E00}, '{16'h18B9, 16'hABCD, 16'hABCD},
      '{16'h18BA, 16'h1234, 16'h0000}, '{16'h1837, 16'h5555, 16'h0000}};
   // Clock of 4 ns.
   always #2 clock_i = ~clock_i;
   sap_sequencer #(.MS_CYCLES(MS)) dut_u (.clock_i, .rst_i, .slave_mode_i, .config_mode_i,
      .own_addr_i, .crc_off_i, .ttl_sel_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
      .reg_rdata_o, .reg_hit_o, .ans_addr_o, .tx_data_o, .tx_valid_o, .tx_ttl_o, .tx_ready_i,
      .busy_o, .entry_o);
   sap_sink sink_u (.clock_i, .slow_i(slow), .stall_i(stall), .tx_data_i(tx_data_o),
      .tx_valid_i(tx_valid_o), .tx_ttl_i(tx_ttl_o), .tx_ready_o(tx_ready_i));
   task automatic chk(string what, logic [15:0] seen, logic [15:0] want);
      compares++;
      if (seen !== want) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic acc(logic wr, logic [15:0] a, logic [15:0] d, logic [15:0] want);
      reg_wr_i <= wr;
      reg_rd_i <= !wr;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      // The answer stands for the single cycle after the taking edge.
      #1;
      if (!wr) chk("rdata", reg_rdata_o, want);
      if (!wr) chk("hit", {15'h0, reg_hit_o}, {15'h0, want != 16'h0 || a == 16'h1838});
      @(posedge clock_i);
   endtask
   // Appends one command, high byte order kept, with optional CRC low then high.
   function automatic void add(logic [7:0] b[$], logic crc_on, logic t);
      logic [15:0] c = SAP_CRC_INIT;
      foreach (b[i]) begin
         c ^= {8'h00, b[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ SAP_CRC_POLY : c >> 1;
         exp.push_back({t, b[i]});
      end
      if (crc_on) exp.push_back({t, c[7:0]});
      if (crc_on) exp.push_back({t, c[15:8]});
   endfunction
   task automatic collect();
      for (int i = 0; i < 3000 && sink_u.rx_q.size() < exp.size(); i++) @(posedge clock_i);
      if (sink_u.rx_q.size() < exp.size()) begin
         error_cnt++;
         complete_run();
      end
      foreach (exp[i]) chk("byte", {7'h0, sink_u.rx_q[i]}, {7'h0, exp[i]});
   endtask
   // Main sequence.
   initial begin
      repeat (20) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      acc(1'b0, 16'h1838, 16'h0, 16'h0000);
      foreach (rows[i]) acc(1'b1, rows[i][0], rows[i][1], 16'h0);
      foreach (rows[i]) acc(1'b0, rows[i][0], 16'h0, rows[i][2]);
      config_mode_i <= 1'b1;
      acc(1'b0, 16'h0000, 16'h0, 16'h0000);
      chk("cfg addr", {8'h0, ans_addr_o}, 16'h0001);
      config_mode_i <= 1'b0;
      acc(1'b0, 16'h0000, 16'h0, 16'h0000);
      chk("own addr", {8'h0, ans_addr_o}, 16'h0042);
      slave_mode_i <= 1'b1;
      add({8'h05, 8'h03, 8'h00}, 1'b1, 1'b1);
      add({8'h7E}, 1'b1, 1'b1);
      exp.push_back(9'h105);
      collect();
      chk("gap", {15'h0, sink_u.ts_q[5] - sink_u.ts_q[4] inside {[5 * MS:5 * MS + 24]}}, 16'h1);
      slave_mode_i <= 1'b0;
      crc_off_i <= 1'b1;
      ttl_sel_i <= 1'b0;
      repeat (80) @(posedge clock_i);
      #1;
      chk("idle", {11'h0, busy_o, entry_o}, 16'h0000);
      sink_u.rx_q.delete();
      exp.delete();
      stall <= 1'b1;
      slave_mode_i <= 1'b1;
      repeat (40) @(posedge clock_i);
      #1;
      chk("stalled", {11'h0, busy_o, entry_o}, 16'h0010);
      stall <= 1'b0;
      add({8'h05, 8'h03, 8'h00, 8'h7E}, 1'b0, 1'b0);
      collect();
      // Mid-run reset empties the table and stops the sequencer.
      slave_mode_i <= 1'b0;
      rst_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      #1;
      chk("reset", {10'h0, tx_valid_o, busy_o, entry_o}, 16'h0000);
      acc(1'b0, 16'h1838, 16'h0, 16'h0000);
      complete_run();
   end
endmodule // sap_sequencer_tb
